// [ssp_clkdiv.sv]
// Internal serial clock generator: toggles a clock at the selected rate.
`default_nettype none
module ssp_clkdiv
   import ssp_pkg::*;
(
   // System
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] rate,
   // Generated clock and edge pulses
   output var  logic       sck_o,
   output var  logic       fall_o,
   output var  logic       rise_o
);
   typedef struct packed
   {
      ssp_div_t cnt;
      logic     sck;
   } cd_st_t;

   cd_st_t st_q;
   cd_st_t st_d;

   // Half period minus one; the clock stays high while not running.
   function automatic ssp_div_t half_period(input logic [2:0] r);
      unique case (r)
         3'b000:  half_period = 13'h0FFF;
         3'b001:  half_period = 13'h007F;
         3'b010:  half_period = 13'h001F;
         3'b011:  half_period = 13'h000F;
         3'b100:  half_period = 13'h0007;
         3'b101:  half_period = 13'h0003;
         3'b110:  half_period = 13'h0001;
         default: half_period = 13'h0001;
      endcase
   endfunction

   always_comb
   begin
      st_d   = st_q;
      fall_o = 1'b0;
      rise_o = 1'b0;
      if (!run)
      begin
         st_d.cnt = '0;
         st_d.sck = 1'b1;
      end
      else if (st_q.cnt == half_period(rate))
      begin
         st_d.cnt = '0;
         st_d.sck = ~st_q.sck;
         fall_o   = st_q.sck;
         rise_o   = ~st_q.sck;
      end
      else
      begin
         st_d.cnt = st_q.cnt + 13'h0001;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= '{cnt: '0, sck: 1'b1};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign sck_o = st_q.sck;
endmodule
`default_nettype wire

// [ssp_core.sv]
// Synchronous serial port: transmit, receive and transmit/receive burst engine.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`default_nettype none
module ssp_core
   import ssp_pkg::*;
(
   // System
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   // AXI4-Lite write response
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Serial pins
   input  wire logic        sck_i,
   output var  logic        sck_o,
   output var  logic        sck_oe,
   input  wire logic        sin_i,
   output var  logic        sout_o,
   // Completion event
   output var  logic        completion_interrupt
);
   import ssp_pkg::*;

   typedef struct packed
   {
      ssp_state_t                fsm;
      ssp_ctrl_t                 ctrl;
      logic [2:0]                count;
      ssp_status_t               st;
      logic [SSP_DEPTH-1:0][7:0] buf_m;
      logic [2:0]                byte_ix;
      logic [2:0]                bit_ix;
      logic [2:0]                rd_ix;
      logic [2:0]                wr_ix;
      logic [7:0]                shreg;
      logic                      sout;
      logic                      sck_prev;
      logic                      done;
      logic                      err_burst;
      logic                      irq;
      logic                      aw_hold;
      logic [3:0]                awaddr;
      logic                      w_hold;
      logic [31:0]               wdata;
      logic [3:0]                wstrb;
      logic                      bvalid;
      logic                      rvalid;
      logic [31:0]               rdata;
      logic [1:0]                rresp;
   } core_st_t;

   core_st_t q;
   core_st_t d;

   logic ext;
   logic fall;
   logic rise;
   logic int_sck;
   logic int_fall;
   logic int_rise;
   logic wr_go;
   logic rd_go;
   logic halt_wr;

   // Picks the bit that goes out next for the chosen order.
   function automatic logic pick_bit(input logic [7:0] b, input logic lsb,
                                     input logic [2:0] ix);
      pick_bit = lsb ? b[ix] : b[3'd7 - ix];
   endfunction

   assign ext = (q.ctrl.sck_sel == SSP_SCK_EXT);

   ssp_clkdiv u_div
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (q.fsm == SSP_RUN && !ext),
      .rate    (q.ctrl.sck_sel),
      .sck_o   (int_sck),
      .fall_o  (int_fall),
      .rise_o  (int_rise)
   );

   // The pin is sampled as synchronous; edges come from the previous level.
   assign fall = ext ? (q.sck_prev & ~sck_i) : int_fall;
   assign rise = ext ? (~q.sck_prev & sck_i) : int_rise;

   assign wr_go = q.aw_hold && q.w_hold && !q.bvalid;
   assign rd_go = s_axi_arvalid && !q.rvalid;
   assign halt_wr = wr_go && q.awaddr == SSP_OFS_CTRL && q.wstrb[0]
                    && q.wdata[SSP_CTL_HALT_BIT];

   always_comb
   begin
      d = q;
      d.irq = 1'b0;
      d.sck_prev = sck_i;
      // Bus handshakes: address and data may arrive in either order.
      if (s_axi_awvalid && !q.aw_hold)
      begin
         d.aw_hold = 1'b1;
         d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_hold)
      begin
         d.w_hold = 1'b1;
         d.wdata  = s_axi_wdata;
         d.wstrb  = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;
      if (q.rvalid && s_axi_rready)
         d.rvalid = 1'b0;

      // Serial engine.
      unique case (q.fsm)
         SSP_IDLE:
         begin
            if (q.ctrl.start && !q.st.rx_full)
            begin
               d.fsm     = SSP_RUN;
               d.st.busy = 1'b1;
               d.byte_ix = '0;
               d.bit_ix  = '0;
               d.done    = 1'b0;
               d.st.tx_empty = 1'b0;
               d.shreg   = q.buf_m[0];
               d.sout    = 1'b1;
            end
         end
         SSP_RUN:
         begin
            if (!q.ctrl.start)
               d.fsm = SSP_STOP;
            else if (fall && q.ctrl.mode != SSP_MODE_RX)
            begin
               // Out bit changes on the falling edge.
               if (ext && q.st.tx_empty)
                  d.st.tx_err = 1'b1;
               else
                  // A register that shifts offers its next bit at one end;
                  // only transmit-only mode walks the bit index.
                  d.sout = pick_bit(q.shreg, q.ctrl.lsb_first,
                                    (q.ctrl.mode == SSP_MODE_TX)
                                    ? q.bit_ix : 3'd0);
            end
            if (q.ctrl.start && rise)
            begin
               if (q.ctrl.mode != SSP_MODE_TX)
               begin
                  if (q.ctrl.lsb_first)
                     d.shreg = {sin_i, q.shreg[7:1]};
                  else
                     d.shreg = {q.shreg[6:0], sin_i};
               end
               d.bit_ix = q.bit_ix + 3'd1;
               if (q.bit_ix == 3'd7)
               begin
                  // A byte has been fully shifted.
                  if (q.st.rx_full && q.ctrl.mode != SSP_MODE_TX && ext)
                     d.st.rx_err = 1'b1;
                  else if (q.ctrl.mode != SSP_MODE_TX)
                     d.buf_m[q.byte_ix] = q.ctrl.lsb_first
                        ? {sin_i, q.shreg[7:1]} : {q.shreg[6:0], sin_i};
                  d.byte_ix = q.byte_ix + 3'd1;
                  d.shreg   = q.buf_m[3'(q.byte_ix + 3'd1)];
                  if (q.byte_ix == q.count)
                  begin
                     d.byte_ix = '0;
                     d.shreg   = q.buf_m[0];
                     d.st.tx_empty = 1'b1;
                     if (!q.st.rx_err || !q.err_burst)
                        d.irq = 1'b1;
                     if (q.st.rx_err)
                        d.err_burst = 1'b1;
                     if (q.ctrl.mode != SSP_MODE_TX && !q.st.rx_err)
                     begin
                        d.st.rx_full = 1'b1;
                        d.rd_ix = '0;
                     end
                  end
               end
            end
         end
         SSP_STOP:
         begin
            d.fsm     = SSP_IDLE;
            d.st.busy = 1'b0;
         end
         default:
            d.fsm = SSP_IDLE;
      endcase
      if (q.st.tx_err || q.st.rx_err)
         d.sout = 1'b1;

      // Register writes.
      if (wr_go)
      begin
         d.aw_hold = 1'b0;
         d.w_hold  = 1'b0;
         d.bvalid  = 1'b1;
         if (q.awaddr == SSP_OFS_CTRL && q.wstrb[0])
         begin
            d.ctrl.sck_sel   = q.wdata[SSP_CTL_SCK_LSB +: 3];
            d.ctrl.lsb_first = q.wdata[SSP_CTL_DIR_BIT];
            d.ctrl.mode      = q.wdata[SSP_CTL_MODE_LSB +: 2];
            d.ctrl.start     = q.wdata[SSP_CTL_START_BIT];
            d.ctrl.halt      = 1'b0;
         end
         else if (q.awaddr == SSP_OFS_COUNT && q.wstrb[0])
            d.count = q.wdata[2:0];
         else if (q.awaddr == SSP_OFS_DATA && q.wstrb[0])
         begin
            d.buf_m[q.wr_ix] = q.wdata[7:0];
            d.wr_ix = (q.wr_ix == q.count) ? 3'd0 : q.wr_ix + 3'd1;
         end
      end
      // Forced halt wins over the serial engine (not a same-cycle completion pulse) and register writes; a data read in the same cycle still moves rd_ix.
      if (halt_wr)
      begin
         d.fsm        = SSP_IDLE;
         d.ctrl.start = 1'b0;
         d.st         = '0;
         d.err_burst  = 1'b0;
         d.byte_ix    = '0;
         d.bit_ix     = '0;
         d.rd_ix      = '0;
         d.wr_ix      = '0;
         d.sout       = 1'b1;
      end

      // Register reads.
      if (rd_go)
      begin
         d.rvalid = 1'b1;
         d.rresp  = 2'b00;
         d.rdata  = '0;
         unique case (s_axi_araddr)
            SSP_OFS_CTRL:   d.rdata[7:0] = q.ctrl;
            SSP_OFS_COUNT:  d.rdata[2:0] = q.count;
            SSP_OFS_STATUS: d.rdata[7:0] = {q.st.busy, 3'b000, q.st.rx_full,
                              q.st.tx_empty, q.st.rx_err, q.st.tx_err};
            SSP_OFS_DATA:
            begin
               d.rdata[7:0] = q.buf_m[q.rd_ix];
               d.rd_ix = (q.rd_ix == q.count) ? 3'd0 : q.rd_ix + 3'd1;
               if (q.st.rx_full && q.rd_ix == q.count)
                  d.st.rx_full = 1'b0;
            end
            default:        d.rresp = 2'b10;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q          <= '0;
         q.fsm      <= SSP_IDLE;
         q.ctrl     <= SSP_CTRL_RST;
         q.count    <= SSP_COUNT_RST;
         q.sout     <= 1'b1;
         q.sck_prev <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign s_axi_awready = !q.aw_hold;
   assign s_axi_wready  = !q.w_hold;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = 2'b00;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign sck_o  = int_sck;
   assign sck_oe = !ext;
   assign sout_o = q.sout;
   assign completion_interrupt = q.irq;
endmodule
`default_nettype wire

// [ssp_core_properties.sv]
// Checker for the serial port core: pin behaviour tied to bus traffic.
`default_nettype none
module ssp_core_properties
   import ssp_pkg::*;
(
   // System
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   // Pins
   input wire logic        sck_o,
   input wire logic        sck_oe,
   input wire logic        sout_o,
   input wire logic        completion_interrupt
);
   logic [3:0] wa_q;
   logic [3:0] ra_q;
   logic [7:0] wd_q;
   logic [1:0] hs_q;
   logic       cw_q;
   logic [1:0] hs_n;
   logic       cw;
   logic       st;
   // A write lands once both halves are taken, in whichever order.
   assign hs_n = hs_q | {s_axi_wvalid & s_axi_wready,
                         s_axi_awvalid & s_axi_awready};
   assign cw = cw_q && wa_q == SSP_OFS_CTRL;
   assign st = s_axi_rvalid && ra_q == SSP_OFS_STATUS;
   always_ff @(posedge aclk)
   begin
      if (s_axi_awvalid && s_axi_awready)
         wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
         wd_q <= s_axi_wdata[7:0];
      if (s_axi_arvalid && s_axi_arready)
         ra_q <= s_axi_araddr;
      hs_q <= (!aresetn || hs_n == 2'b11) ? 2'b00 : hs_n;
      cw_q <= aresetn && hs_n == 2'b11;
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_irq_pulse: assert property (
      completion_interrupt |=> !completion_interrupt)
      else $error("completion pulse too long");
   a_clk_source: assert property (
      cw |-> ##[1:3] (sck_oe == (wd_q[2:0] != SSP_SCK_EXT)))
      else $error("clock enable ignores clock select");
   a_int_start: assert property (
      cw && wd_q[7:6] == 2'b10 && wd_q[2:0] == 3'h6 |-> ##[1:12] !sck_o)
      else $error("internal clock did not start");
   a_halt_sck: assert property (
      cw && wd_q[6] |-> ##[1:3] sck_o [*4])
      else $error("clock runs after halt");
   a_halt_irq: assert property (
      cw && wd_q[6] |=> !completion_interrupt [*8])
      else $error("completion after halt");
   a_err_sout: assert property (
      st && |s_axi_rdata[1:0] |-> sout_o)
      else $error("output low during error");
   a_idle_sck: assert property (
      st && !s_axi_rdata[SSP_ST_BUSY] |-> sck_o)
      else $error("clock low while not busy");
   a_halt_read: assert property (
      s_axi_rvalid && ra_q == SSP_OFS_CTRL |-> !s_axi_rdata[6])
      else $error("halt bit reads one");
   c_irq: cover property (completion_interrupt);
   c_halt: cover property (cw && wd_q[6]);
   c_err: cover property (st && |s_axi_rdata[1:0]);
endmodule
bind ssp_core ssp_core_properties u_props (.*);
`default_nettype wire

// [ssp_peer.sv]
// Serial peer model: clocks the line or follows it, shifts bits both ways.
`default_nettype none
module ssp_peer
(
   // System
   input  wire logic aclk,
   // Line
   input  wire logic ext,
   input  wire logic sck_o,
   input  wire logic sout_o,
   output var  logic sck_i,
   output var  logic sin_i
);
   timeunit 1ns;
   timeprecision 1ns;
   bit        txq[$];
   bit        rxq[$];
   logic      ln_q = 1'b1;
   wire logic ln = ext ? sck_i : sck_o;
   initial
   begin
      sck_i = 1'b1;
      sin_i = 1'b1;
   end
   // Out of a frame the data line flips rather than hold a stale bit.
   always @(posedge aclk)
   begin
      ln_q <= ln;
      if (ln_q && !ln)
         sin_i <= txq.size() > 0 ? txq.pop_front() : ~sin_i;
      if (!ln_q && ln)
         rxq.push_back(sout_o);
   end
   // Six-cycle low and seven-cycle high levels keep both above the minimum width.
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge aclk);
         sck_i <= 1'b0;
         repeat (6) @(posedge aclk);
         sck_i <= 1'b1;
         repeat (6) @(posedge aclk);
      end
   endtask
endmodule
`default_nettype wire

// [ssp_pkg.sv]
// Package for the synchronous serial port: register map, fields, states.
`default_nettype none
package ssp_pkg;
   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [3:0] SSP_OFS_CTRL   = 4'h0;
   localparam logic [3:0] SSP_OFS_COUNT  = 4'h4;
   localparam logic [3:0] SSP_OFS_STATUS = 4'h8;
   localparam logic [3:0] SSP_OFS_DATA   = 4'hC;
   // Control register fields.
   localparam int SSP_CTL_SCK_LSB   = 0;
   localparam int SSP_CTL_DIR_BIT   = 3;
   localparam int SSP_CTL_MODE_LSB  = 4;
   localparam int SSP_CTL_HALT_BIT  = 6;
   localparam int SSP_CTL_START_BIT = 7;
   // Status register bits.
   localparam int SSP_ST_BUSY  = 7;
   localparam int SSP_ST_RXF   = 3;
   localparam int SSP_ST_TXE   = 2;
   localparam int SSP_ST_RECEIVE_ERROR_FLAG = 1;
   localparam int SSP_ST_TRANSMIT_ERROR_FLAG = 0;
   // Field encodings.
   localparam logic [1:0] SSP_MODE_TX   = 2'b00;
   localparam logic [1:0] SSP_MODE_RX   = 2'b01;
   localparam logic [1:0] SSP_MODE_TXRX = 2'b10;
   localparam logic [2:0] SSP_SCK_EXT   = 3'b111;
   // Buffer depth and reset values.
   localparam int         SSP_DEPTH     = 8;
   localparam logic [7:0] SSP_CTRL_RST  = 8'h00;
   localparam logic [2:0] SSP_COUNT_RST = 3'h0;
   // Internal clock divider: half period minus one, in system clocks, per rate code.
   localparam int SSP_DIV_W = 13;
   typedef logic [SSP_DIV_W-1:0] ssp_div_t;

   typedef enum logic [2:0]
   {
      SSP_IDLE = 3'b001,
      SSP_RUN  = 3'b010,
      SSP_STOP = 3'b100
   } ssp_state_t;

   typedef struct packed
   {
      logic       start;
      logic       halt;
      logic [1:0] mode;
      logic       lsb_first;
      logic [2:0] sck_sel;
   } ssp_ctrl_t;

   typedef struct packed
   {
      logic busy;
      logic rx_full;
      logic tx_empty;
      logic rx_err;
      logic tx_err;
   } ssp_status_t;
endpackage
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the serial port core with a modelled peer.
`default_nettype none
module tb_top;
   import ssp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = 1'b0, aresetn = 1'b0, ext = 1'b1;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        sck_i, sck_o, sck_oe, sin_i, sout_o;
   logic        completion_interrupt;
   int          err_count = 0, total_checks = 0, irqs = 0;
   int          seed = 32'h5b08a339;
   logic [7:0]  cfg;
   logic [7:0]  rxm[$];
   logic [7:0]  txm[$];
   always #25 aclk = ~aclk;
   always @(posedge aclk)
      if (completion_interrupt === 1'b1)
         irqs <= irqs + 1;
   ssp_core DUT (.*);
   ssp_peer peer (.*);
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic hang;
      chk("wait", 32'h0, 32'h1);
      end_sim;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      int   n;
      logic fa, fw, fb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'($random(seed)), d};
      s_axi_wstrb <= {3'($random(seed)), 1'b1};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 99 && (n == 0 || s_axi_bready); n++)
      begin
         @(negedge aclk);
         fa = s_axi_awready & s_axi_awvalid;
         fw = s_axi_wready & s_axi_wvalid;
         fb = s_axi_bvalid;
         if (fb)
            chk("bresp", 32'h0, 32'(s_axi_bresp));
         @(posedge aclk);
         if (fa)
            s_axi_awvalid <= 1'b0;
         if (fw)
            s_axi_wvalid <= 1'b0;
         if (fb)
            s_axi_bready <= 1'b0;
      end
      if (n >= 99)
         hang();
   endtask
   task automatic rc(input string nm, input logic [3:0] a,
                     input logic [7:0] m, e);
      int          n;
      logic        fa, fr;
      logic [31:0] q;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 99 && (n == 0 || s_axi_rready); n++)
      begin
         @(negedge aclk);
         fa = s_axi_arready & s_axi_arvalid;
         fr = s_axi_rvalid;
         if (fr)
         begin
            q = s_axi_rdata;
            chk("rresp", 32'h0, 32'(s_axi_rresp));
         end
         @(posedge aclk);
         if (fa)
            s_axi_arvalid <= 1'b0;
         if (fr)
            s_axi_rready <= 1'b0;
      end
      if (n >= 99)
         hang();
      chk(nm, {24'h00_0000, e}, q & {24'h00_0000, m});
   endtask
   // Loads count, mode and transmit bytes, then sets the start bit.
   task automatic arm(input logic [7:0] cf, input int nb);
      logic [7:0] b;
      ext <= (cf[2:0] == SSP_SCK_EXT);
      cfg = cf;
      rxm.delete();
      txm.delete();
      peer.txq.delete();
      peer.rxq.delete();
      wr(SSP_OFS_COUNT, 8'(nb - 1));
      wr(SSP_OFS_CTRL, cf);
      repeat (nb)
      begin
         b = 8'($random(seed));
         rxm.push_back(b);
         for (int j = 0; j < 8; j++)
            peer.txq.push_back(cf[3] ? b[j] : b[7 - j]);
         b = 8'($random(seed));
         txm.push_back(b);
         if (cf[5:4] != SSP_MODE_RX)
            wr(SSP_OFS_DATA, b);
      end
      wr(SSP_OFS_CTRL, cf | 8'h80);
   endtask
   task automatic halt;
      wr(SSP_OFS_CTRL, cfg | 8'h40);
      rc("halt status", SSP_OFS_STATUS, 8'h8B, 8'h00);
   endtask
   task automatic burst(input logic [1:0] md, input logic lsb,
                        input logic [2:0] sel, input int nb);
      int k;
      int n;
      k = irqs;
      arm({2'b00, md, lsb, sel}, nb);
      if (ext)
         peer.pulses(8 * nb);
      for (n = 0; n < 2000 && irqs <= k; n++)
         @(posedge aclk);
      wr(SSP_OFS_CTRL, cfg);
      chk("irq count", 32'(k + 1), 32'(irqs));
      rc("status", SSP_OFS_STATUS, 8'h8B,
         (md == SSP_MODE_TX) ? 8'h00 : 8'h08);
      if (md != SSP_MODE_TX)
         foreach (rxm[i])
            rc("rx byte", SSP_OFS_DATA, 8'hFF, rxm[i]);
      rc("full clear", SSP_OFS_STATUS, 8'h08, 8'h00);
      if (md != SSP_MODE_RX)
         foreach (txm[i])
            for (int j = 0; j < 8; j++)
               chk("tx bit", 32'(lsb ? txm[i][j] : txm[i][7 - j]),
                   32'(peer.rxq[8 * i + j]));
   endtask
   initial
   begin
      int k;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      burst(SSP_MODE_RX, 1'b0, SSP_SCK_EXT, 2);
      burst(SSP_MODE_TX, 1'b0, SSP_SCK_EXT, 2);
      burst(SSP_MODE_TXRX, 1'b1, SSP_SCK_EXT, 3);
      burst(SSP_MODE_TXRX, 1'b0, 3'h6, 8);
      burst(SSP_MODE_RX, 1'b1, 3'h6, 1);
      arm({2'b00, SSP_MODE_TXRX, 1'b0, SSP_SCK_EXT}, 1);
      peer.pulses(4);
      k = irqs;
      halt();
      rc("halt ctrl", SSP_OFS_CTRL, 8'hFF, cfg);
      peer.pulses(4);
      chk("halt irq", 32'(k), 32'(irqs));
      arm({2'b00, SSP_MODE_RX, 1'b0, SSP_SCK_EXT}, 1);
      peer.pulses(16);
      rc("rx error", SSP_OFS_STATUS, 8'h0A, 8'h0A);
      chk("sout high", 32'h1, 32'(sout_o));
      k = irqs;
      peer.pulses(8);
      chk("irq after error", 32'(k + 1), 32'(irqs));
      peer.pulses(8);
      chk("irq repeat", 32'(k + 1), 32'(irqs));
      halt();
      arm({2'b00, SSP_MODE_TXRX, 1'b1, SSP_SCK_EXT}, 1);
      peer.pulses(9);
      rc("tx error", SSP_OFS_STATUS, 8'h05, 8'h05);
      chk("sout forced", 32'h1, 32'(sout_o));
      halt();
      end_sim;
   end
endmodule
`default_nettype wire
